/* core/smaeb_builder.sv */
/*
  Health attribute entry builder: holds seven 12-byte attribute entries and
  answers byte reads from the sector assembly logic by sector byte offset.
  Assumes all counters and factory settings come from logic on the same clock.
*/

`timescale 1ns/1ps

module smaeb_builder #(
  parameter int SLOT_COUNT = smaeb_pkg::MAX_ENTRIES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte read port from the sector assembly logic
  input wire logic rd_en,
  input wire logic [smaeb_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_valid,
  output logic rd_hit,
  output logic [7:0] rd_data,
  // worst flash chip spare block counts
  input wire logic [23:0] spare_init_worst,
  input wire logic [23:0] spare_cur_worst,
  // wear counters and factory settings
  input wire logic [47:0] erase_total,
  input wire logic [47:0] erase_target_total,
  input wire logic erase_prefail,
  input wire logic [7:0] erase_threshold,
  // error and activity counters
  input wire logic [31:0] ecc_total,
  input wire logic [31:0] ecc_corr,
  input wire logic [31:0] crc_err,
  input wire logic [47:0] flash_reads,
  input wire logic [31:0] power_cycles,
  // life estimate state
  output logic [7:0] life_pct,
  output logic [7:0] life_worst,
  output logic threshold_exceeded
);

  // ------------------------------------------------------------------------
  // entry packing
  // ------------------------------------------------------------------------

  // lays out one entry, low byte of every field at the lowest offset
  function automatic logic [smaeb_pkg::ENTRY_BITS-1:0] make_entry(
    input logic [7:0] id,
    input logic [15:0] flags,
    input logic [7:0] cur,
    input logic [7:0] worst,
    input logic [47:0] raw
  );
    make_entry = {smaeb_pkg::RSVD_BYTE, raw, worst, cur, flags, id};
  endfunction

  // picks one byte out of an entry
  function automatic logic [7:0] entry_byte(
    input logic [smaeb_pkg::ENTRY_BITS-1:0] entry,
    input logic [3:0] idx
  );
    entry_byte = entry[idx*8 +: 8];
  endfunction

  // ------------------------------------------------------------------------
  // life estimate state machine
  // ------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SMAEB_IDLE = 3'b001,
    SMAEB_DIV = 3'b010,
    SMAEB_DONE = 3'b100
  } smaeb_state_e;

  // divider and life figure registers with their next values
  smaeb_state_e state_reg, state_next;
  logic [smaeb_pkg::NUM_W-1:0] num_reg, num_next;
  logic [smaeb_pkg::NUM_W-1:0] quo_reg, quo_next;
  logic [smaeb_pkg::DIV_W:0] rem_reg, rem_next;
  logic [smaeb_pkg::DIV_W-1:0] div_reg, div_next;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] life_reg, life_next;
  logic [7:0] worst_reg, worst_next;
  logic exceed_reg, exceed_next;
  // helpers of the divider step
  logic [smaeb_pkg::DIV_W:0] rem_shift;
  logic [7:0] used_pct;
  logic [smaeb_pkg::NUM_W-1:0] scaled_erases;

  // erases scaled by one hundred so the quotient is a percentage
  assign scaled_erases = ({8'h00, erase_total} << 6) + ({8'h00, erase_total} << 5)
    + ({8'h00, erase_total} << 2);

  // next state of the restoring divider and the life figures
  always_comb begin
    state_next = state_reg;
    num_next = num_reg;
    quo_next = quo_reg;
    rem_next = rem_reg;
    div_next = div_reg;
    bit_cnt_next = bit_cnt_reg;
    life_next = life_reg;
    worst_next = worst_reg;
    rem_shift = {rem_reg[smaeb_pkg::DIV_W-1:0], num_reg[smaeb_pkg::NUM_W-1]};
    used_pct = smaeb_pkg::PCT_FULL;
    if (quo_reg < {48'h0000_0000_0000, smaeb_pkg::PCT_FULL}) begin
      used_pct = quo_reg[7:0];
    end
    case (state_reg)
      SMAEB_IDLE: begin
        // snapshot the counter and target, restart a division
        if (erase_target_total != 48'h0000_0000_0000) begin
          num_next = scaled_erases;
          div_next = erase_target_total;
          quo_next = '0;
          rem_next = '0;
          bit_cnt_next = 6'(smaeb_pkg::NUM_W - 1);
          state_next = SMAEB_DIV;
        end
      end
      SMAEB_DIV: begin
        // one quotient bit per clock
        num_next = {num_reg[smaeb_pkg::NUM_W-2:0], 1'b0};
        if (rem_shift >= {1'b0, div_reg}) begin
          rem_next = rem_shift - {1'b0, div_reg};
          quo_next = {quo_reg[smaeb_pkg::NUM_W-2:0], 1'b1};
        end else begin
          rem_next = rem_shift;
          quo_next = {quo_reg[smaeb_pkg::NUM_W-2:0], 1'b0};
        end
        if (bit_cnt_reg == 6'h00) begin
          state_next = SMAEB_DONE;
        end else begin
          bit_cnt_next = bit_cnt_reg - 6'h01;
        end
      end
      SMAEB_DONE: begin
        // remaining life, clamped at zero once the target is used up
        life_next = smaeb_pkg::PCT_FULL - used_pct;
        if (life_next < worst_reg) begin
          worst_next = life_next;
        end
        state_next = SMAEB_IDLE;
      end
      default: begin
        state_next = SMAEB_IDLE;
      end
    endcase
    // exceeded tracks the life figure of the same edge
    exceed_next = (life_next < erase_threshold);
  end

  // registers of the life estimate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= SMAEB_IDLE;
      num_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
      div_reg <= '0;
      bit_cnt_reg <= 6'h00;
      life_reg <= smaeb_pkg::PCT_FULL;
      worst_reg <= smaeb_pkg::PCT_FULL;
      exceed_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      num_reg <= num_next;
      quo_reg <= quo_next;
      rem_reg <= rem_next;
      div_reg <= div_next;
      bit_cnt_reg <= bit_cnt_next;
      life_reg <= life_next;
      worst_reg <= worst_next;
      exceed_reg <= exceed_next;
    end
  end

  // life figures straight from their registers
  assign life_pct = life_reg;
  assign life_worst = worst_reg;
  assign threshold_exceeded = exceed_reg;

  // ------------------------------------------------------------------------
  // entry contents
  // ------------------------------------------------------------------------
  // one packed entry per built slot
  logic [smaeb_pkg::ENTRY_BITS-1:0] entries [smaeb_pkg::NUM_ATTRS];
  logic [15:0] erase_flags;

  // flag type of the erase entry is a factory setting
  assign erase_flags = erase_prefail ? smaeb_pkg::FLAGS_PREFAIL
    : smaeb_pkg::FLAGS_ADVISORY;

  // all seven entries, in slot order
  always_comb begin
    // slot 1: worst-chip spare blocks
    entries[smaeb_pkg::SLOT_WORST_SPARE - smaeb_pkg::SLOT_FIRST] = make_entry(
      smaeb_pkg::ID_WORST_SPARE, smaeb_pkg::FLAGS_ADVISORY,
      smaeb_pkg::FIXED_VALUE, smaeb_pkg::FIXED_VALUE,
      {spare_cur_worst, spare_init_worst});
    // slot 2: erase count with life estimate
    entries[smaeb_pkg::SLOT_ERASE - smaeb_pkg::SLOT_FIRST] = make_entry(
      smaeb_pkg::ID_ERASE, erase_flags,
      life_reg, worst_reg,
      erase_total);
    // slot 3: all ECC errors
    entries[smaeb_pkg::SLOT_ECC_TOTAL - smaeb_pkg::SLOT_FIRST] = make_entry(
      smaeb_pkg::ID_ECC_TOTAL, smaeb_pkg::FLAGS_ADVISORY,
      smaeb_pkg::FIXED_VALUE, smaeb_pkg::FIXED_VALUE,
      {16'h0000, ecc_total});
    // slot 4: correctable ECC errors only
    entries[smaeb_pkg::SLOT_ECC_CORR - smaeb_pkg::SLOT_FIRST] = make_entry(
      smaeb_pkg::ID_ECC_CORR, smaeb_pkg::FLAGS_ADVISORY,
      smaeb_pkg::FIXED_VALUE, smaeb_pkg::FIXED_VALUE,
      {16'h0000, ecc_corr});
    // slot 5: UDMA CRC errors
    entries[smaeb_pkg::SLOT_CRC - smaeb_pkg::SLOT_FIRST] = make_entry(
      smaeb_pkg::ID_CRC, smaeb_pkg::FLAGS_ADVISORY,
      smaeb_pkg::FIXED_VALUE, smaeb_pkg::FIXED_VALUE,
      {16'h0000, crc_err});
    // slot 6: flash read commands
    entries[smaeb_pkg::SLOT_READS - smaeb_pkg::SLOT_FIRST] = make_entry(
      smaeb_pkg::ID_READS, smaeb_pkg::FLAGS_ADVISORY,
      smaeb_pkg::FIXED_VALUE, smaeb_pkg::FIXED_VALUE,
      flash_reads);
    // slot 7: power-on cycles
    entries[smaeb_pkg::SLOT_POWER - smaeb_pkg::SLOT_FIRST] = make_entry(
      smaeb_pkg::ID_POWER, smaeb_pkg::FLAGS_ADVISORY,
      smaeb_pkg::FIXED_VALUE, smaeb_pkg::FIXED_VALUE,
      {16'h0000, power_cycles});
  end

  // ------------------------------------------------------------------------
  // byte read port
  // ------------------------------------------------------------------------
  // offset split and the registered answer
  logic [smaeb_pkg::ADDR_W-1:0] rel_off;
  logic [smaeb_pkg::ADDR_W-1:0] slot_idx;
  logic [3:0] byte_idx;
  logic [7:0] data_next, data_reg;
  logic hit_next, hit_reg;
  logic valid_next, valid_reg;
  logic [smaeb_pkg::ADDR_W-1:0] local_slot;

  // splits the sector offset into slot and byte within the entry
  always_comb begin
    rel_off = rd_addr - smaeb_pkg::ADDR_W'(smaeb_pkg::ENTRY_BASE);
    slot_idx = rel_off / smaeb_pkg::ADDR_W'(smaeb_pkg::ENTRY_BYTES);
    byte_idx = 4'(rel_off % smaeb_pkg::ADDR_W'(smaeb_pkg::ENTRY_BYTES));
    local_slot = slot_idx - smaeb_pkg::ADDR_W'(smaeb_pkg::SLOT_FIRST);
    data_next = data_reg;
    hit_next = hit_reg;
    valid_next = rd_en;
    // every miss answers zero with hit low
    if (rd_en) begin
      data_next = 8'h00;
      hit_next = 1'b0;
      if (rd_addr < smaeb_pkg::ADDR_W'(smaeb_pkg::ENTRY_BASE)) begin
        hit_next = 1'b0;
      end else if (slot_idx >= smaeb_pkg::ADDR_W'(SLOT_COUNT)) begin
        hit_next = 1'b0;
      end else if (slot_idx < smaeb_pkg::ADDR_W'(smaeb_pkg::SLOT_FIRST)) begin
        hit_next = 1'b0;
      end else if (local_slot < smaeb_pkg::ADDR_W'(smaeb_pkg::NUM_ATTRS)) begin
        hit_next = 1'b1;
        data_next = entry_byte(entries[local_slot[2:0]], byte_idx);
      end
    end
  end

  // registers of the read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_reg <= 8'h00;
      hit_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      hit_reg <= hit_next;
      valid_reg <= valid_next;
    end
  end

  // read answer straight from its registers
  assign rd_valid = valid_reg;
  assign rd_hit = hit_reg;
  assign rd_data = data_reg;

endmodule

/* core/smaeb_pkg.sv */
/*
  Constants for the health attribute entry builder: entry layout, attribute
  identifiers, flag words, fixed values and slot placement in the data sector.
  Assumes the sector assembly logic addresses the sector byte by byte.
*/
package smaeb_pkg;

  // ------------------------------------------------------------------------
  // sector and entry layout
  // ------------------------------------------------------------------------
  localparam int ENTRY_BYTES = 12;
  localparam int ENTRY_BITS = 96;
  localparam int ENTRY_BASE = 2;
  localparam int MAX_ENTRIES = 30;
  localparam int NUM_ATTRS = 7;
  localparam int ADDR_W = 9;

  // byte positions inside one entry
  localparam int POS_ID = 0;
  localparam int POS_FLAGS = 1;
  localparam int POS_CUR = 3;
  localparam int POS_WORST = 4;
  localparam int POS_RAW = 5;
  localparam int POS_RAW_HI = 8;
  localparam int POS_RSVD = 11;

  // ------------------------------------------------------------------------
  // attribute identifiers
  // ------------------------------------------------------------------------
  localparam logic [7:0] ID_WORST_SPARE = 8'hd5;
  localparam logic [7:0] ID_ERASE = 8'he5;
  localparam logic [7:0] ID_ECC_TOTAL = 8'hcb;
  localparam logic [7:0] ID_ECC_CORR = 8'hcc;
  localparam logic [7:0] ID_CRC = 8'hc7;
  localparam logic [7:0] ID_READS = 8'he8;
  localparam logic [7:0] ID_POWER = 8'h0c;

  // ------------------------------------------------------------------------
  // flag words and fixed values
  // ------------------------------------------------------------------------
  localparam logic [15:0] FLAGS_ADVISORY = 16'h0002;
  localparam logic [15:0] FLAGS_PREFAIL = 16'h0003;
  localparam logic [7:0] FIXED_VALUE = 8'h64;
  localparam logic [7:0] RSVD_BYTE = 8'h00;

  // ------------------------------------------------------------------------
  // slot order of the entries built here (slot 0 is filled elsewhere)
  // ------------------------------------------------------------------------
  localparam int SLOT_FIRST = 1;
  localparam int SLOT_WORST_SPARE = 1;
  localparam int SLOT_ERASE = 2;
  localparam int SLOT_ECC_TOTAL = 3;
  localparam int SLOT_ECC_CORR = 4;
  localparam int SLOT_CRC = 5;
  localparam int SLOT_READS = 6;
  localparam int SLOT_POWER = 7;

  // ------------------------------------------------------------------------
  // life estimate divider
  // ------------------------------------------------------------------------
  localparam int NUM_W = 56;
  localparam int DIV_W = 48;
  localparam logic [7:0] PCT_FULL = 8'h64;

endpackage

/* tb/smaeb_builder_properties.sv */
/*
  Checker for the entry builder read port and life state.
  Assumes it is bound to smaeb_builder and sees only its ports.
*/
`timescale 1ns/1ps

module smaeb_builder_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // read port
  input wire logic rd_en,
  input wire logic [smaeb_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_valid,
  input wire logic rd_hit,
  input wire logic [7:0] rd_data,
  // factory flag and life state
  input wire logic erase_prefail,
  input wire logic [7:0] life_pct,
  input wire logic [7:0] life_worst
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // one read taken at a given sector offset
  sequence s_take(int a);
    rd_en && rd_addr == a;
  endsequence

  // offset inside the seven built slots
  sequence s_in_slots;
    rd_en && rd_addr >= 14 && rd_addr < 98;
  endsequence

  a_valid_follows_read: assert property (rd_en |=> rd_valid)
    else $error("no valid after a read");
  a_no_stray_valid: assert property (!rd_en |=> !rd_valid)
    else $error("valid without a read");
  a_data_holds: assert property (!rd_en |=> $stable(rd_data) && $stable(rd_hit))
    else $error("read data moved without a read");
  a_low_offset_miss: assert property (rd_en && rd_addr < 2 |=> !rd_hit && rd_data == 8'h00)
    else $error("offset below entries answered");
  a_spare_id: assert property (s_take(14) |=> rd_hit && rd_data == 8'hd5)
    else $error("worst spare id wrong");
  a_erase_id: assert property (s_take(26) |=> rd_data == 8'he5)
    else $error("erase id wrong");
  a_erase_flags: assert property (s_take(27) |=> rd_data == {7'h00, 1'b1, $past(erase_prefail)})
    else $error("erase flags wrong");
  a_reserved_zero: assert property (s_in_slots ##0 (rd_addr - 2) % 12 == 11
    |=> rd_hit && rd_data == 8'h00) else $error("reserved byte not zero");
  a_fixed_value: assert property (s_in_slots ##0 ((rd_addr - 2) % 12 inside {3, 4})
    ##0 !(rd_addr inside {[26:37]}) |=> rd_data == 8'h64) else $error("fixed value wrong");
  a_worst_is_min: assert property (life_worst <= $past(life_worst) && life_worst <= life_pct)
    else $error("worst life not a minimum");
endmodule

bind smaeb_builder smaeb_builder_properties u_props (.clk(clk), .rst_n(rst_n), .rd_en(rd_en),
  .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data),
  .erase_prefail(erase_prefail), .life_pct(life_pct), .life_worst(life_worst));

/* tb/smaeb_reader_model.sv */
/*
  Sector assembly reader model: issues one byte read per cycle.
  Assumes a single bench process calls issue and rest.
*/
`timescale 1ns/1ps

module smaeb_reader_model (
  // clock
  input wire logic clk,
  // read request to the builder
  output logic rd_en,
  output logic [smaeb_pkg::ADDR_W-1:0] rd_addr
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 9'h000;
  end

  // set a request just after the edge and hold it one cycle
  task automatic issue(input logic [smaeb_pkg::ADDR_W-1:0] a);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    rd_addr = a;
  endtask

  // drop the request; the idle offset shows the inverted last value
  task automatic rest();
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    rd_addr = ~rd_addr;
  endtask
endmodule

/* tb/tb.sv */
/*
  Testbench for the entry builder: sweeps all entry bytes, edge offsets
  and life steps. Assumes the reader model and the bound checker.
*/
`timescale 1ns/1ps

module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_en, rd_valid, rd_hit, erase_prefail, threshold_exceeded;
  logic [smaeb_pkg::ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data, erase_threshold, life_pct, life_worst;
  logic [23:0] spare_init_worst, spare_cur_worst;
  logic [47:0] erase_total, erase_target_total, flash_reads;
  logic [31:0] ecc_total, ecc_corr, crc_err, power_cycles;
  logic [8:0] exp_q[$];
  logic [47:0] er [3] = '{48'h0000_012c, 48'h0000_0032, 48'h0000_1388};
  logic [7:0] thr [3] = '{8'h50, 8'h5f, 8'h01};
  logic [7:0] lp [3] = '{8'h46, 8'h5f, 8'h00};
  logic [7:0] lw [3] = '{8'h46, 8'h46, 8'h00};
  logic tx [3] = '{1'b1, 1'b0, 1'b1};
  logic [7:0] exp_life = 8'h64;
  logic [7:0] exp_worst = 8'h64;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 23;

  // 100 MHz clock
  always #5 clk = ~clk;

  smaeb_reader_model rdr (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr));

  smaeb_builder uut (.clk(clk), .rst_n(rst_n), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data),
    .spare_init_worst(spare_init_worst), .spare_cur_worst(spare_cur_worst),
    .erase_total(erase_total), .erase_target_total(erase_target_total),
    .erase_prefail(erase_prefail), .erase_threshold(erase_threshold),
    .ecc_total(ecc_total), .ecc_corr(ecc_corr), .crc_err(crc_err),
    .flash_reads(flash_reads), .power_cycles(power_cycles), .life_pct(life_pct),
    .life_worst(life_worst), .threshold_exceeded(threshold_exceeded));

  // expected {hit, byte} at a sector offset, entries packed low byte first
  function automatic logic [8:0] expect_byte(int a);
    logic [95:0] e;
    if (a < 14 || a > 97) return 9'h000;
    case ((a - 2) / 12)
      1: e = {8'h00, spare_cur_worst, spare_init_worst, 16'h6464, 16'h0002, 8'hd5};
      2: e = {8'h00, erase_total, exp_worst, exp_life, 15'h0001, erase_prefail, 8'he5};
      3: e = {24'h00_0000, ecc_total, 16'h6464, 16'h0002, 8'hcb};
      4: e = {24'h00_0000, ecc_corr, 16'h6464, 16'h0002, 8'hcc};
      5: e = {24'h00_0000, crc_err, 16'h6464, 16'h0002, 8'hc7};
      6: e = {8'h00, flash_reads, 16'h6464, 16'h0002, 8'he8};
      default: e = {24'h00_0000, power_cycles, 16'h6464, 16'h0002, 8'h0c};
    endcase
    return {1'b1, e[((a - 2) % 12) * 8 +: 8]};
  endfunction

  // count one comparison and report a difference
  task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // print the counts and the verdict, then stop
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // note the expected answer, then issue the read
  task automatic rd(int a);
    exp_q.push_back(expect_byte(a));
    rdr.issue(9'(a));
  endtask

  // bounded wait for a new life value
  task automatic wait_life(logic [7:0] want);
    int i;
    for (i = 0; i < 300 && life_pct !== want; i++) begin
      @(posedge clk);
      #1;
    end
    chk("life wait", {1'b0, want}, {1'b0, life_pct});
    if (i == 300) wrap_up();
  endtask

  // monitor: take the oldest note whenever an answer appears
  always @(posedge clk) begin
    #1;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("stray answer", 9'h1ff, {rd_hit, rd_data});
      else chk("read byte", exp_q.pop_front(), {rd_hit, rd_data});
    end
  end

  // main sequence
  initial begin
    {spare_init_worst, spare_cur_worst, flash_reads} = '0;
    {ecc_total, ecc_corr, crc_err, power_cycles} = '0;
    erase_total = 48'h0000_0000;
    erase_target_total = 48'h0000_03e8;
    erase_prefail = 1'b0;
    erase_threshold = 8'h50;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("worst at reset", 9'h064, {1'b0, life_worst});
    // life steps: 30 percent used, 5 percent with equal threshold, capped
    for (int k = 0; k < 3; k++) begin
      erase_threshold = thr[k];
      erase_total = er[k];
      exp_life = lp[k];
      exp_worst = lw[k];
      wait_life(lp[k]);
      chk("worst life", {1'b0, lw[k]}, {1'b0, life_worst});
      chk("exceeded", {8'h00, tx[k]}, {8'h00, threshold_exceeded});
    end
    // sweep every built byte and the edges, both flag settings
    for (int p = 0; p < 2; p++) begin
      erase_prefail = p[0];
      spare_init_worst = 24'($random(seed));
      spare_cur_worst = 24'($random(seed));
      {ecc_total, ecc_corr, crc_err, power_cycles} = {$random(seed), $random(seed),
        $random(seed), $random(seed)};
      flash_reads = {16'($random(seed)), 32'($random(seed))};
      for (int a = 0; a < 102; a++) rd(a);
      rd(361);
      rd(511);
      rdr.rest();
      repeat (3) @(posedge clk);
      #1;
    end
    chk("reads left", 9'h000, 9'(exp_q.size()));
    wrap_up();
  end
endmodule
